// *** pkg/arrival_pkg.sv ***
package arrival_pkg;
	// frequency and current word widths
	localparam int FREQ_W = 16;
	localparam int CUR_W = 16;
	// hysteresis margins in percent of max frequency
	localparam int ON_PCT = 1;
	localparam int OFF_PCT = 2;
	localparam int PCT_FULL = 100;
	// first current limit default: 100 percent of rated current, rated in the same units
	localparam logic [15:0] LIMIT_A_DEFAULT = 16'h0064;
	// output option codes
	localparam logic [7:0] OPT_SPEED_REACHED = 8'h01;
	localparam logic [7:0] OPT_OVER_SPEED = 8'h02;
	localparam logic [7:0] OPT_CURRENT_A = 8'h03;
	localparam logic [7:0] OPT_AT_THRESHOLD = 8'h06;
	localparam logic [7:0] OPT_CURRENT_B = 8'h07;
endpackage : arrival_pkg

// *** rtl/band_detect.sv ***
// hysteresis band test around one threshold
module band_detect #(
	parameter int W = 16
) (
	input wire logic [W-1:0] i_freq,
	input wire logic [W-1:0] i_thresh,
	input wire logic [W-1:0] i_on_margin,
	input wire logic [W-1:0] i_off_margin,
	output logic o_in_on_band,
	output logic o_in_off_band,
	output logic o_at_or_above_on,
	output logic o_below_off
);
	logic [W:0] lo_on;
	logic [W:0] lo_off;
	logic [W:0] hi_on;
	logic [W:0] hi_off;
	logic [W:0] f;

	// widened by one bit so margins never wrap
	always_comb
	begin
		f = {1'b0, i_freq};
		lo_on = ({1'b0, i_thresh} > {1'b0, i_on_margin}) ? ({1'b0, i_thresh} - {1'b0, i_on_margin}) : '0;
		lo_off = ({1'b0, i_thresh} > {1'b0, i_off_margin}) ? ({1'b0, i_thresh} - {1'b0, i_off_margin}) : '0;
		hi_on = {1'b0, i_thresh} + {1'b0, i_on_margin};
		hi_off = {1'b0, i_thresh} + {1'b0, i_off_margin};
		o_in_on_band = (f >= lo_on) && (f <= hi_on);
		o_in_off_band = (f >= lo_off) && (f <= hi_off);
		o_at_or_above_on = (f >= lo_on);
		o_below_off = (f < lo_off);
	end
endmodule : band_detect

// *** rtl/arrival_flags.sv ***
// What this block does
// - with option 01 the speed-reached flag is on while the output frequency is at the set speed, else off.
// - option 02 gives the over-speed flag: on at or above the accel threshold while speeding up, off below decel threshold while slowing.
// - the speed-reached flag switches around the set speed parameter.
// - every arrival flag turns on early by 1% of the maximum frequency.
// - every arrival flag turns off late by 2% of the maximum frequency; at-threshold also drops at once when steady.
// - over-speed turns on at the accel threshold and off at the decel threshold, which may be equal.
// - the at-threshold flag drops again once the frequency moves past its threshold, a pulse per direction.
// - all arrival functions may sit on separate terminals at once, each evaluated on its own.
// - with option 03 the first current warning is on when current is above its limit.
// - the first current warning is off when current is below its limit.
// - the second current warning compares against its own limit.
// - current detection stays active while driving and while braking regeneratively.
// - the first current limit defaults to 100% of rated current after reset.
// - an asserted warning drives its terminal active, closing a normally-open contact, else inactive.
module arrival_flags #(
	parameter int N_TERM = 5,
	parameter int FREQ_W = arrival_pkg::FREQ_W,
	parameter int CUR_W = arrival_pkg::CUR_W
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic [FREQ_W-1:0] i_out_freq,
	input wire logic [FREQ_W-1:0] i_max_freq,
	input wire logic [FREQ_W-1:0] i_set_speed_param,
	input wire logic [FREQ_W-1:0] i_accel_threshold,
	input wire logic [FREQ_W-1:0] i_decel_threshold,
	input wire logic i_accelerating,
	input wire logic i_decelerating,
	input wire logic [CUR_W-1:0] i_out_current,
	input wire logic i_limit_a_load,
	input wire logic [CUR_W-1:0] i_current_limit_a,
	input wire logic [CUR_W-1:0] i_current_limit_b,
	input wire logic [N_TERM*8-1:0] i_term_option,
	output logic o_speed_reached_flag,
	output logic o_over_speed_flag,
	output logic o_at_threshold_pulse,
	output logic o_current_warn_a,
	output logic o_current_warn_b,
	output logic [N_TERM-1:0] o_term_active,
	output logic [CUR_W-1:0] o_current_limit_a
);
	// elaboration guard: option fields are bytes, margins need headroom
	if (N_TERM < 1 || FREQ_W < 8 || CUR_W < 8)
	begin : g_bad_params
		$error("arrival_flags: unsupported parameters");
	end

	logic [FREQ_W-1:0] on_margin;
	logic [FREQ_W-1:0] off_margin;
	logic [FREQ_W+7:0] on_prod;
	logic [FREQ_W+7:0] off_prod;

	always_comb
	begin
		on_prod = ({8'h00, i_max_freq} * (FREQ_W+8)'(arrival_pkg::ON_PCT)) / (FREQ_W+8)'(arrival_pkg::PCT_FULL);
		off_prod = ({8'h00, i_max_freq} * (FREQ_W+8)'(arrival_pkg::OFF_PCT)) / (FREQ_W+8)'(arrival_pkg::PCT_FULL);
		on_margin = on_prod[FREQ_W-1:0];
		off_margin = off_prod[FREQ_W-1:0];
	end

	logic set_on_band;
	logic set_off_band;
	logic acc_on_band;
	logic acc_off_band;
	logic acc_above_on;
	logic dec_on_band;
	logic dec_off_band;
	logic dec_below_off;

	band_detect #(.W(FREQ_W)) u_set (
		.i_freq(i_out_freq),
		.i_thresh(i_set_speed_param),
		.i_on_margin(on_margin),
		.i_off_margin(off_margin),
		.o_in_on_band(set_on_band),
		.o_in_off_band(set_off_band),
		.o_at_or_above_on(),
		.o_below_off()
	);

	band_detect #(.W(FREQ_W)) u_acc (
		.i_freq(i_out_freq),
		.i_thresh(i_accel_threshold),
		.i_on_margin(on_margin),
		.i_off_margin(off_margin),
		.o_in_on_band(acc_on_band),
		.o_in_off_band(acc_off_band),
		.o_at_or_above_on(acc_above_on),
		.o_below_off()
	);

	band_detect #(.W(FREQ_W)) u_dec (
		.i_freq(i_out_freq),
		.i_thresh(i_decel_threshold),
		.i_on_margin(on_margin),
		.i_off_margin(off_margin),
		.o_in_on_band(dec_on_band),
		.o_in_off_band(dec_off_band),
		.o_at_or_above_on(),
		.o_below_off(dec_below_off)
	);

	logic speed_reached;
	logic over_speed;
	logic at_threshold;
	logic warn_a;
	logic warn_b;
	logic [CUR_W-1:0] limit_a;
	logic next_speed_reached;
	logic next_over_speed;
	logic next_at_threshold;
	logic next_warn_a;
	logic next_warn_b;
	logic [CUR_W-1:0] next_limit_a;

	// flag next-state with hysteresis; held flags use the wider off band
	always_comb
	begin
		// on inside on band, held inside off band
		next_speed_reached = speed_reached ? set_off_band : set_on_band;
		// set on accel crossing, clear on decel drop
		// accel on point, decel off point
		next_over_speed = over_speed;
		if (i_accelerating && acc_above_on)
			next_over_speed = 1'b1;
		else if (i_decelerating && dec_below_off)
			next_over_speed = 1'b0;
		// on near the threshold of the current direction
		// drops once frequency leaves the band
		if (i_accelerating)
			next_at_threshold = at_threshold ? acc_off_band : acc_on_band;
		else if (i_decelerating)
			next_at_threshold = at_threshold ? dec_off_band : dec_on_band;
		else
			next_at_threshold = 1'b0;
		// above limit, off below; equal keeps the last state
		// magnitude only, so driving and regeneration alike
		if (i_out_current > limit_a)
			next_warn_a = 1'b1;
		else if (i_out_current < limit_a)
			next_warn_a = 1'b0;
		else
			next_warn_a = warn_a;
		// own limit for the second warning
		if (i_out_current > i_current_limit_b)
			next_warn_b = 1'b1;
		else if (i_out_current < i_current_limit_b)
			next_warn_b = 1'b0;
		else
			next_warn_b = warn_b;
		next_limit_a = i_limit_a_load ? i_current_limit_a : limit_a;
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_n)
		begin
			speed_reached <= 1'b0;
			over_speed <= 1'b0;
			at_threshold <= 1'b0;
			warn_a <= 1'b0;
			warn_b <= 1'b0;
			limit_a <= CUR_W'(arrival_pkg::LIMIT_A_DEFAULT);
		end
		else
		begin
			speed_reached <= next_speed_reached;
			over_speed <= next_over_speed;
			at_threshold <= next_at_threshold;
			warn_a <= next_warn_a;
			warn_b <= next_warn_b;
			limit_a <= next_limit_a;
		end
	end

	logic [N_TERM-1:0] next_term;

	always_comb
	begin
		for (int t = 0; t < N_TERM; t++)
		begin
			unique case (i_term_option[t*8 +: 8])
				arrival_pkg::OPT_SPEED_REACHED: next_term[t] = next_speed_reached;
				arrival_pkg::OPT_OVER_SPEED: next_term[t] = next_over_speed;
				arrival_pkg::OPT_CURRENT_A: next_term[t] = next_warn_a;
				arrival_pkg::OPT_AT_THRESHOLD: next_term[t] = next_at_threshold;
				arrival_pkg::OPT_CURRENT_B: next_term[t] = next_warn_b;
				default: next_term[t] = 1'b0;
			endcase
		end
	end

	// outputs registered; terminals match the flags in the same cycle
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_n)
			o_term_active <= '0;
		else
			o_term_active <= next_term;
	end

	assign o_speed_reached_flag = speed_reached;
	assign o_over_speed_flag = over_speed;
	assign o_at_threshold_pulse = at_threshold;
	assign o_current_warn_a = warn_a;
	assign o_current_warn_b = warn_b;
	assign o_current_limit_a = limit_a;
endmodule : arrival_flags

// *** tb/relay_contacts.sv ***
// normally-open contacts of the relays hung on the output terminals
module relay_contacts (
	input wire logic [4:0] i_coil,
	output logic [4:0] o_contact
);
	timeunit 1ns;
	timeprecision 1ps;
	// contact follows coil
	// ideal relay, no bounce modelled, so contacts follow the coil at once
	assign o_contact = i_coil;
endmodule : relay_contacts

// *** tb/arrival_flags_chk.sv ***
// watches the flag outputs against the comparator inputs
module arrival_flags_chk #(
	parameter int N_TERM = 5,
	parameter int FREQ_W = arrival_pkg::FREQ_W,
	parameter int CUR_W = arrival_pkg::CUR_W
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic [FREQ_W-1:0] i_out_freq,
	input wire logic [FREQ_W-1:0] i_max_freq,
	input wire logic [FREQ_W-1:0] i_set_speed_param,
	input wire logic [FREQ_W-1:0] i_accel_threshold,
	input wire logic [FREQ_W-1:0] i_decel_threshold,
	input wire logic i_accelerating,
	input wire logic i_decelerating,
	input wire logic [CUR_W-1:0] i_out_current,
	input wire logic i_limit_a_load,
	input wire logic [CUR_W-1:0] i_current_limit_b,
	input wire logic [N_TERM*8-1:0] i_term_option,
	input wire logic o_speed_reached_flag,
	input wire logic o_over_speed_flag,
	input wire logic o_at_threshold_pulse,
	input wire logic o_current_warn_a,
	input wire logic o_current_warn_b,
	input wire logic [N_TERM-1:0] o_term_active,
	input wire logic [CUR_W-1:0] o_current_limit_a
);
	timeunit 1ns;
	timeprecision 1ps;
	int f, s, on_m, off_m;
	// signed arithmetic so a low threshold minus its margin cannot wrap
	assign f = int'(i_out_freq);
	assign s = int'(i_set_speed_param);
	assign on_m = int'(i_max_freq) / 100;
	assign off_m = int'(i_max_freq) * 2 / 100;
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_n);
	property p_spd_on;
		f >= s - on_m && f <= s + on_m |=> o_speed_reached_flag;
	endproperty
	a_spd_on: assert property (p_spd_on) else $error("speed flag not on in band");
	property p_spd_off;
		f < s - off_m || f > s + off_m |=> !o_speed_reached_flag;
	endproperty
	a_spd_off: assert property (p_spd_off) else $error("speed flag on outside band");
	property p_ovr_on;
		i_accelerating && f >= int'(i_accel_threshold) - on_m |=> o_over_speed_flag;
	endproperty
	a_ovr_on: assert property (p_ovr_on) else $error("over speed not set");
	property p_ovr_off;
		i_decelerating && !i_accelerating && f < int'(i_decel_threshold) - off_m |=> !o_over_speed_flag;
	endproperty
	a_ovr_off: assert property (p_ovr_off) else $error("over speed not cleared");
	property p_thr_idle;
		!i_accelerating && !i_decelerating |=> !o_at_threshold_pulse;
	endproperty
	a_thr_idle: assert property (p_thr_idle) else $error("threshold pulse while steady");
	property p_warn_a;
		!i_limit_a_load && i_out_current > o_current_limit_a |=> o_current_warn_a;
	endproperty
	a_warn_a: assert property (p_warn_a) else $error("warning a missed");
	property p_warn_b;
		i_out_current < i_current_limit_b |=> !o_current_warn_b;
	endproperty
	a_warn_b: assert property (p_warn_b) else $error("warning b on below limit");
	property p_term;
		i_term_option[7:0] == arrival_pkg::OPT_SPEED_REACHED |=> o_term_active[0] == o_speed_reached_flag;
	endproperty
	a_term: assert property (p_term) else $error("terminal 0 not following speed flag");
	c_spd: cover property (o_speed_reached_flag);
	c_pulse: cover property (o_at_threshold_pulse ##1 !o_at_threshold_pulse);
	c_warn: cover property (o_current_warn_a && o_current_warn_b);
endmodule : arrival_flags_chk
bind arrival_flags arrival_flags_chk #(.N_TERM(N_TERM), .FREQ_W(FREQ_W), .CUR_W(CUR_W)) arrival_flags_chk_i (.*);

// *** tb/arrival_flags_test.sv ***
module arrival_flags_test;
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
	logic i_clk_sys, i_rst_n, acc, dec, load;
	logic [15:0] freq, maxf, setp, acc_t, dec_t, cur, lim_a, lim_b;
	logic [39:0] opt;
	logic spd, ovr, thr, wa, wb;
	logic [4:0] term, contact;
	logic [15:0] lim_q;
	int failures = 0;
	int comparisons = 0;
	arrival_flags arrival_flags_i (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_out_freq(freq),
		.i_max_freq(maxf), .i_set_speed_param(setp), .i_accel_threshold(acc_t), .i_decel_threshold(dec_t),
		.i_accelerating(acc), .i_decelerating(dec), .i_out_current(cur), .i_limit_a_load(load),
		.i_current_limit_a(lim_a), .i_current_limit_b(lim_b), .i_term_option(opt),
		.o_speed_reached_flag(spd), .o_over_speed_flag(ovr), .o_at_threshold_pulse(thr),
		.o_current_warn_a(wa), .o_current_warn_b(wb), .o_term_active(term), .o_current_limit_a(lim_q));
	relay_contacts relay_contacts_i (.i_coil(term), .o_contact(contact));
	initial
	begin
		i_clk_sys = 1'b0;
		forever #5 i_clk_sys = ~i_clk_sys;
	end
	// one sample edge, then let the registered outputs settle
	task drv(input logic [15:0] f, input logic a, input logic d, input logic [15:0] c);
		freq = f;
		acc = a;
		dec = d;
		cur = c;
		@(posedge i_clk_sys);
		#1;
	endtask : drv
	task end_of_test;
		$display("comparisons=%0d failures=%0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_of_test
	// max 1000 gives margins of 10 on and 20 off
	initial
	begin
		{i_rst_n, acc, dec, load, freq, cur, lim_a} = '0;
		{maxf, setp, acc_t, dec_t, lim_b} = {16'h03e8, 16'h01f4, 16'h012c, 16'h012c, 16'h0032};
		opt = 40'h0703060201;
		repeat (12) @(posedge i_clk_sys);
		#1;
		i_rst_n = 1'b1;
		`CHK(lim_q, 16'h0064)
		`CHK(term, 5'h00)
		drv(16'h01e9, 1'b1, 1'b0, 16'h0000);
		`CHK({spd, ovr}, 2'b01)
		drv(16'h01ea, 1'b1, 1'b0, 16'h0000);
		`CHK({spd, term[0]}, 2'b11)
		drv(16'h0208, 1'b0, 1'b0, 16'h0000);
		`CHK({spd, thr}, 2'b10)
		drv(16'h0209, 1'b0, 1'b0, 16'h0000);
		`CHK({spd, ovr}, 2'b01)
		drv(16'h0119, 1'b0, 1'b1, 16'h0000);
		`CHK({ovr, thr}, 2'b10)
		drv(16'h0122, 1'b0, 1'b1, 16'h0000);
		`CHK({ovr, thr, term[2]}, 3'b111)
		drv(16'h0117, 1'b0, 1'b1, 16'h0000);
		`CHK({ovr, thr, term}, 7'h00)
		drv(16'h0136, 1'b1, 1'b0, 16'h0000);
		`CHK({ovr, thr}, 2'b11)
		drv(16'h0140, 1'b1, 1'b0, 16'h0000);
		`CHK(thr, 1'b1)
		drv(16'h0141, 1'b1, 1'b0, 16'h0000);
		`CHK(thr, 1'b0)
		load = 1'b1;
		lim_a = 16'h00c8;
		drv(16'h0141, 1'b0, 1'b1, 16'h0000);
		load = 1'b0;
		`CHK(lim_q, 16'h00c8)
		drv(16'h0141, 1'b0, 1'b1, 16'h00c9);
		`CHK({wa, wb, contact}, 7'h7a)
		drv(16'h0141, 1'b0, 1'b1, 16'h00c7);
		`CHK({wa, contact}, 6'h12)
		drv(16'h0141, 1'b0, 1'b1, 16'h0031);
		`CHK({wb, contact}, 6'h02)
		// max 2000 widens the on band to 20: 480 is inside only if margins track max
		maxf = 16'h07d0;
		drv(16'h01e0, 1'b0, 1'b0, 16'h0000);
		`CHK({spd, term[0]}, 2'b11)
		// mid-run reset drops the loaded limit back to its default
		i_rst_n = 1'b0;
		drv(16'h01e0, 1'b0, 1'b0, 16'h0000);
		i_rst_n = 1'b1;
		`CHK({lim_q, spd, ovr, term}, {16'h0064, 7'h00})
		end_of_test();
	end
endmodule : arrival_flags_test
